// *** bench/qot_encoder.sv ***
`timescale 1ns/1ns
`default_nettype none

// quadrature source and trigger pulser on the timer pins
module qot_encoder (
    input  wire logic clk,
    output logic      ph_a,
    output logic      ph_b
);
    localparam logic [7:0] UP_SEQ = 8'h78;  // a,b: 01 11 10 00

    initial begin
        ph_a = 1'b0;
        ph_b = 1'b0;
    end

    // n full cycles, each phase held gap+1 clocks; down swaps a and b
    task automatic turn(input logic up, input int n, input int gap);
        logic [1:0] s;
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 4; k++) begin
                s = UP_SEQ[7 - 2 * k -: 2];
                @(posedge clk);
                ph_a <= up ? s[1] : s[0];
                ph_b <= up ? s[0] : s[1];
                repeat (gap) @(posedge clk);
            end
        end
    endtask

    // falling edge on the input pin as one-shot trigger
    task automatic trig();
        @(posedge clk);
        ph_a <= 1'b1;
        repeat (3) @(posedge clk);
        ph_a <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// *** bench/qot_timer_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module qot_timer_bench;
    logic        clk, rst_n, cyc, stb, we, ext_ovf;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat, dat_o;
    logic        ack, pin_o, oe_n, ev, ph_a, ph_b;
    wire logic   aux_wire;
    int          err_count, n_compared, ev_count, hi_len, ev0;

    // pin level: device drives while oe_n low
    assign aux_wire = oe_n ? ph_b : pin_o;

    qot_timer u_dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .count_input_pin(ph_a), .aux_io_pin_i(aux_wire), .aux_io_pin_o(pin_o),
        .aux_io_pin_oe_n(oe_n), .ext_overflow(ext_ovf), .event_req(ev)
    );

    qot_encoder u_enc (
        .clk(clk), .ph_a(ph_a), .ph_b(ph_b)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // event pulses and pulse-output high time
    always @(posedge clk) begin
        if (ev === 1'b1) ev_count <= ev_count + 1;
        if (pin_o === 1'b1) hi_len <= hi_len + 1;
    end

    task automatic stop_test();
        $display("errors=%0d compared=%0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // classic wishbone single cycle
    // ----------------------------------------
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin err_count++; stop_test(); end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        `CHK(rdat, e)
    endtask

    // waits for an event within lim clocks, compares the hit count
    task automatic wait_ev(input int lim, input int hits);
        int n;
        n = 0;
        ev0 = ev_count;
        while (ev_count == ev0 && n < lim) begin @(posedge clk); n++; end
        `CHK(ev_count - ev0, hits)
        repeat (4) @(posedge clk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {cyc, stb, we, ext_ovf} = 4'h0;
        adr = 4'h0;
        wdat = 32'h0000_0000;
        rst_n = 1'b0;
        err_count = 0;
        n_compared = 0;
        ev_count = 0;
        hi_len = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK(oe_n, 1'b1)
        rd(qot_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0000);
        rd(4'hC, 32'h0000_0000);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0010);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0010);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0001);
        u_enc.turn(1'b1, 3, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0013);
        u_enc.turn(1'b0, 2, 3);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0011);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0009);
        u_enc.turn(1'b1, 1, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0015);
        u_enc.turn(1'b0, 2, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_000D);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0000);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0002);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0001);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0005);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0002);
        ev0 = ev_count;
        u_enc.turn(1'b0, 3, 2);
        `CHK(ev_count - ev0, 1)
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0005);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0000);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_FFFE);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0001);
        ev0 = ev_count;
        u_enc.turn(1'b1, 2, 2);
        `CHK(ev_count - ev0, 1)
        rd(qot_pkg::ADDR_TIMER, 32'h0000_FFFE);
        rd(qot_pkg::ADDR_STATUS, 32'h0000_0003);
        wb(1'b1, qot_pkg::ADDR_STATUS, 32'h0000_0001);
        rd(qot_pkg::ADDR_STATUS, 32'h0000_0002);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0000);
        u_enc.turn(1'b1, 2, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_FFFE);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0000);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0011);
        u_enc.turn(1'b0, 1, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_FFFF);
        u_enc.turn(1'b1, 1, 1);
        rd(qot_pkg::ADDR_TIMER, 32'h0000_0000);
        // one-shot: software, pin and overflow triggers
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0000);
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0005);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0085);
        `CHK(oe_n, 1'b0)
        hi_len = 0;
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0087);
        wait_ev(40, 1);
        `CHK(hi_len, 5)
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_00A5);
        u_enc.trig();
        wait_ev(40, 1);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_00C5);
        @(posedge clk);
        ext_ovf <= 1'b1;
        @(posedge clk);
        ext_ovf <= 1'b0;
        wait_ev(40, 1);
        // prescaled count source: two ticks of eight clocks
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0002);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0185);
        hi_len = 0;
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0187);
        wait_ev(60, 1);
        `CHK(hi_len, 16)
        // retrigger and stop by clearing start
        wb(1'b1, qot_pkg::ADDR_TIMER, 32'h0000_0014);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0085);
        hi_len = 0;
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0087);
        repeat (10) @(posedge clk);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0087);
        wait_ev(60, 1);
        `CHK(hi_len >= 30, 1'b1)
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0087);
        repeat (5) @(posedge clk);
        wb(1'b1, qot_pkg::ADDR_CTRL, 32'h0000_0084);
        wait_ev(60, 0);
        `CHK(pin_o, 1'b0)
        stop_test();
    end
endmodule

`default_nettype wire

// *** hdl/qot_pkg.sv ***
package qot_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_TIMER  = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_START    = 0;  // count start flag
    localparam int CTRL_OS_START = 1;  // one-shot start, write-one pulse
    localparam int CTRL_MODE     = 2;  // 0 two-phase event, 1 one-shot
    localparam int CTRL_X4       = 3;  // multiply-by-4 decoding
    localparam int CTRL_FREERUN  = 4;  // no reload on wrap
    localparam int CTRL_TRIG_LSB = 5;  // 2-bit trigger source
    localparam int CTRL_PULSE_EN = 7;  // drive pulse output
    localparam int CTRL_PRE_LSB  = 8;  // 2-bit prescaler select
    localparam int CTRL_W        = 10;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int STAT_IRQ     = 0;  // sticky event flag, write one to clear
    localparam int STAT_RUNNING = 1;

    // ------------------------------------------------------------
    // trigger sources and prescaler
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_SOFT = 2'h0;
    localparam logic [1:0] TRIG_PIN  = 2'h1;
    localparam logic [1:0] TRIG_OVF  = 2'h2;

    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [4:0]  PRE_DIV1  = 5'h00;
    localparam logic [4:0]  PRE_DIV8  = 5'h07;
    localparam logic [4:0]  PRE_DIV32 = 5'h1F;

endpackage

// *** hdl/qot_timer.sv ***
`timescale 1ns/1ns
`default_nettype none

module qot_timer #(
    parameter bit TWO_PHASE_OK = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        count_input_pin,
    input  wire logic        aux_io_pin_i,
    output logic             aux_io_pin_o,
    output logic             aux_io_pin_oe_n,
    input  wire logic        ext_overflow,
    output logic             event_req
);

    typedef enum logic [2:0] {
        QOT_IDLE = 3'b001,
        QOT_RUN  = 3'b010,
        QOT_DONE = 3'b100
    } qot_state_t;

    typedef struct packed {
        qot_state_t  st;
        logic [qot_pkg::CTRL_W-1:0] ctrl;
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [4:0]  pre;
        logic        in_s;
        logic        aux_s;
        logic        irq;
        logic        evt;
        logic        pout;
        logic        ack;
        logic [31:0] rdat;
    } qot_regs_t;

    qot_regs_t q, d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // prescaler terminal count for the selected count source
    function automatic logic [4:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h1:    pre_limit = qot_pkg::PRE_DIV8;
            2'h2:    pre_limit = qot_pkg::PRE_DIV32;
            default: pre_limit = qot_pkg::PRE_DIV1;
        endcase
    endfunction

    // byte-lane merge of a bus write into a register
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
        lane16 = old;
        if (sel[0]) lane16[7:0]  = wd[7:0];
        if (sel[1]) lane16[15:8] = wd[15:8];
    endfunction

    logic        bus_req;
    logic        wr_ctrl;
    logic        wr_timer;
    logic        wr_stat;
    logic [15:0] ctrl_wd;
    logic        in_rise;
    logic        in_fall;
    logic        aux_rise;
    logic        aux_fall;
    logic        up_ev;
    logic        dn_ev;
    logic        two_phase;
    logic        one_shot;
    logic        trig;
    logic        tick;
    logic [15:0] wval;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign bus_req  = wb_cyc_i && wb_stb_i && !q.ack;
    assign wr_ctrl  = bus_req && wb_we_i && (wb_adr_i == qot_pkg::ADDR_CTRL);
    assign wr_timer = bus_req && wb_we_i && (wb_adr_i == qot_pkg::ADDR_TIMER);
    assign wr_stat  = bus_req && wb_we_i && (wb_adr_i == qot_pkg::ADDR_STATUS);
    assign ctrl_wd  = lane16({6'h00, q.ctrl}, wb_dat_i, wb_sel_i);
    assign wval     = lane16(q.rld, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------
    // pin edge detection (pins are synchronous)
    // ------------------------------------------------------------
    assign in_rise  = count_input_pin && !q.in_s;
    assign in_fall  = !count_input_pin && q.in_s;
    assign aux_rise = aux_io_pin_i && !q.aux_s;
    assign aux_fall = !aux_io_pin_i && q.aux_s;

    // ------------------------------------------------------------
    // two-phase decode
    // ------------------------------------------------------------
    assign two_phase = TWO_PHASE_OK && !q.ctrl[qot_pkg::CTRL_MODE];
    assign one_shot  = q.ctrl[qot_pkg::CTRL_MODE];
    always_comb begin
        up_ev = 1'b0;
        dn_ev = 1'b0;
        if (q.ctrl[qot_pkg::CTRL_X4]) begin
            // phase of the other pin sets direction for each edge
            up_ev = (in_rise && aux_io_pin_i) || (in_fall && !aux_io_pin_i)
                 || (aux_rise && !count_input_pin) || (aux_fall && count_input_pin);
            dn_ev = (in_fall && aux_io_pin_i) || (in_rise && !aux_io_pin_i)
                 || (aux_fall && !count_input_pin) || (aux_rise && count_input_pin);
        end else begin
            up_ev = in_rise && aux_io_pin_i;
            dn_ev = in_fall && aux_io_pin_i;
        end
    end

    // one-shot trigger selection
    always_comb begin
        case (q.ctrl[qot_pkg::CTRL_TRIG_LSB +: 2])
            qot_pkg::TRIG_PIN: trig = in_fall;
            qot_pkg::TRIG_OVF: trig = ext_overflow;
            default:           trig = 1'b0;
        endcase
        if (wr_ctrl && ctrl_wd[qot_pkg::CTRL_OS_START]) begin
            trig = 1'b1;
        end
    end

    assign tick = (q.pre == pre_limit(q.ctrl[qot_pkg::CTRL_PRE_LSB +: 2]));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d       = q;
        d.in_s  = count_input_pin;
        d.aux_s = aux_io_pin_i;
        d.evt   = 1'b0;
        d.ack   = bus_req;
        d.pre   = tick ? 5'h00 : q.pre + 5'h01;
        if (q.st != QOT_RUN) begin
            d.pre = 5'h00;
        end

        // control register; one-shot start bit never stored
        if (wr_ctrl) begin
            d.ctrl = ctrl_wd[qot_pkg::CTRL_W-1:0];
            d.ctrl[qot_pkg::CTRL_OS_START] = 1'b0;
        end

        case (q.st)
            QOT_IDLE: begin
                if (two_phase && q.ctrl[qot_pkg::CTRL_START]) begin
                    d.st = QOT_RUN;
                end else if (one_shot && q.ctrl[qot_pkg::CTRL_START] && trig) begin
                    d.st   = QOT_RUN;
                    d.cnt  = q.rld;
                    d.pout = q.ctrl[qot_pkg::CTRL_PULSE_EN];
                end
            end
            QOT_RUN: begin
                if (!q.ctrl[qot_pkg::CTRL_START]) begin
                    d.st   = QOT_IDLE;
                    d.pout = 1'b0;
                end else if (!one_shot) begin
                    if (up_ev && !dn_ev) begin
                        if (q.cnt == qot_pkg::CNT_MAX) begin
                            d.evt = 1'b1;
                            d.cnt = q.ctrl[qot_pkg::CTRL_FREERUN] ? qot_pkg::CNT_ZERO : q.rld;
                        end else begin
                            d.cnt = q.cnt + 16'h0001;
                        end
                    end else if (dn_ev && !up_ev) begin
                        if (q.cnt == qot_pkg::CNT_ZERO) begin
                            d.evt = 1'b1;
                            d.cnt = q.ctrl[qot_pkg::CTRL_FREERUN] ? qot_pkg::CNT_MAX : q.rld;
                        end else begin
                            d.cnt = q.cnt - 16'h0001;
                        end
                    end
                end else if (trig) begin
                    d.cnt = q.rld;
                    d.pre = 5'h00;
                end else if (tick) begin
                    if (q.cnt <= 16'h0001) begin
                        d.evt  = 1'b1;
                        d.cnt  = q.rld;
                        d.pout = 1'b0;
                        d.st   = QOT_DONE;
                    end else begin
                        d.cnt = q.cnt - 16'h0001;
                    end
                end
            end
            QOT_DONE: begin
                d.st = QOT_IDLE;
            end
            default: begin
                d.st = QOT_IDLE;
            end
        endcase

        // timer register writes
        if (wr_timer) begin
            d.rld = wval;
            if (q.st != QOT_RUN) begin
                d.cnt = wval;
            end
        end

        // sticky flag: set beats clear
        if (wr_stat && wb_sel_i[0] && wb_dat_i[qot_pkg::STAT_IRQ]) begin
            d.irq = 1'b0;
        end
        if (d.evt) begin
            d.irq = 1'b1;
        end

        // read data
        d.rdat = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                qot_pkg::ADDR_CTRL:   d.rdat = {22'h000000, q.ctrl};
                qot_pkg::ADDR_TIMER:  d.rdat = {16'h0000, q.cnt};
                qot_pkg::ADDR_STATUS: d.rdat = {30'h00000000, q.st == QOT_RUN, q.irq};
                default:              d.rdat = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q.st   <= QOT_IDLE;
            q.ctrl <= '0;
            q.cnt  <= qot_pkg::TIMER_RST;
            q.rld  <= qot_pkg::TIMER_RST;
            q.pre  <= 5'h00;
            q.in_s <= 1'b0;
            q.aux_s <= 1'b0;
            q.irq  <= 1'b0;
            q.evt  <= 1'b0;
            q.pout <= 1'b0;
            q.ack  <= 1'b0;
            q.rdat <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_dat_o        = q.rdat;
    assign wb_ack_o        = q.ack;
    assign event_req       = q.evt;
    assign aux_io_pin_o    = q.pout;
    assign aux_io_pin_oe_n = !(one_shot && q.ctrl[qot_pkg::CTRL_PULSE_EN]);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_halt_write_both: assert property (@(posedge clk) disable iff (!rst_n)
        wr_timer && q.st == QOT_IDLE |=> q.cnt == q.rld) else $error("halted write missed counter");
    a_run_write_rld: assert property (@(posedge clk) disable iff (!rst_n)
        wr_timer && q.st == QOT_RUN && !one_shot && !up_ev && !dn_ev |=> q.cnt == $past(q.cnt))
        else $error("running write hit counter");
    a_wrap_reload: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_RUN && !one_shot && q.ctrl[qot_pkg::CTRL_START] && !q.ctrl[qot_pkg::CTRL_FREERUN]
        && up_ev && !dn_ev && q.cnt == qot_pkg::CNT_MAX && !wr_timer |=> q.cnt == $past(q.rld) && event_req)
        else $error("overflow reload wrong");
    a_freerun_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_RUN && !one_shot && q.ctrl[qot_pkg::CTRL_START] && q.ctrl[qot_pkg::CTRL_FREERUN]
        && dn_ev && !up_ev && q.cnt == qot_pkg::CNT_ZERO && !wr_timer |=> q.cnt == qot_pkg::CNT_MAX)
        else $error("free-run wrap wrong");
    a_stop_on_clear: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_RUN && !q.ctrl[qot_pkg::CTRL_START] |=> q.st == QOT_IDLE) else $error("no halt");
    a_oneshot_end: assert property (@(posedge clk) disable iff (!rst_n)
        event_req && one_shot |-> q.st == QOT_DONE && !aux_io_pin_o) else $error("one-shot end wrong");
    a_evt_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
        event_req |=> q.irq) else $error("flag not set");
    a_pulse_in_run: assert property (@(posedge clk) disable iff (!rst_n)
        aux_io_pin_o |-> q.st == QOT_RUN) else $error("pulse outside countdown");

    c_oneshot_done: cover property (@(posedge clk) disable iff (!rst_n) q.st == QOT_DONE);
    c_overflow: cover property (@(posedge clk) disable iff (!rst_n) event_req && !one_shot);
    c_retrigger: cover property (@(posedge clk) disable iff (!rst_n) q.st == QOT_RUN && one_shot && trig);
    c_x4_edge: cover property (@(posedge clk) disable iff (!rst_n) q.st == QOT_RUN && q.ctrl[qot_pkg::CTRL_X4] && aux_rise);

    // ------------------------------------------------------------
    // one-shot, halt and bus checks
    // ------------------------------------------------------------
    // end of countdown leaves the set value in the counter
    a_oneshot_reload: assert property (@(posedge clk) disable iff (!rst_n)
        event_req && one_shot |-> q.cnt == $past(q.rld)) else $error("one-shot end without reload");
    // a finished countdown does not restart by itself
    a_oneshot_stop: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_DONE |=> q.st == QOT_IDLE && !aux_io_pin_o) else $error("one-shot kept running");
    // trigger while running reloads and keeps running
    a_retrig_reload: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_RUN && one_shot && q.ctrl[qot_pkg::CTRL_START] && trig && !wr_timer
        |=> q.cnt == $past(q.rld) && q.st == QOT_RUN) else $error("retrigger did not reload");
    // halted event counter holds its value
    a_halt_hold: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == QOT_IDLE && !one_shot && !wr_timer |=> $stable(q.cnt)) else $error("halted counter moved");
    // read data is zero outside the answer cycle
    a_rdat_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
    // every taken request is answered on the next edge
    a_ack_next: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req |=> wb_ack_o) else $error("request not answered");

endmodule

`default_nettype wire
